// file: csp_cfg_ctrl.sv
// configuration-phase control: init wait, progress flags, ready/strobe, select and scan gating
//
// Summary of operation
// (RULE_01) without boundary-scan selected, every boundary-scan function is off once configuration is done.
// (RULE_02) the outside party keeps tck or tms at one during configuration.
// (RULE_03) in asynchronous peripheral mode the ready output shows whether another byte may be written.
// (RULE_04) a read while selected in asynchronous peripheral mode shows the same ready status on the status data line.
// (RULE_05) in master parallel mode the ready pin is the read strobe toward the external memory.
// (RULE_06) the active-high progress flag stays high until configuration completes.
// (RULE_07) the active-low progress flag stays low until configuration completes.
// (RULE_08) the open-drain init line is pulled low while power settles and memory is cleared.
// (RULE_09) while init is held low from outside the block waits and does not begin configuration.
// (RULE_10) in peripheral, slave parallel and micro modes the device is selected only with low select low and high select high.
// (RULE_11) after configuration the scan pins become user I/O if boundary-scan is not used.
// (RULE_12) the mode pins are captured on the rising edge of init during power-up.
// (RULE_13) the open-drain done output is released high once configuration has completed.
module csp_cfg_ctrl (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire csp_pkg::csp_pins_s pins_i,
    input wire logic load_done_i,
    input wire logic byte_busy_i,
    input wire logic fetch_req_i,
    input wire logic bscan_sel_i,
    output logic init_o,
    output logic init_oe_o,
    output logic done_o,
    output logic done_oe_o,
    output logic cfg_active_high_flag_o,
    output logic cfg_active_low_flag_o,
    output logic rdy_o,
    output logic status_data_line_o,
    output logic status_data_line_oe_o,
    output logic selected_o,
    output logic [csp_pkg::MODE_W-1:0] mode_o,
    output logic bscan_en_o,
    output logic jtag_user_io_o,
    output logic scan_hold_err_o
);
    import csp_pkg::*;

    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;
    logic [PIN_W-1:0] sync3_r;
    logic [PIN_W-1:0] flt_r;
    csp_pins_s pins_f;
    csp_state_e state_r;
    csp_state_e state_nxt;
    logic [CLR_CNT_W-1:0] clr_cnt_r;
    logic init_prev_r;
    logic init_rise;
    logic [MODE_W-1:0] mode_r;
    logic sel_mode;
    logic sel_now;
    logic in_cfg_nxt;
    logic od_r;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // three stages per pin; a change is accepted only when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    sync1_r[gi] <= PIN_RST[gi];
                    sync2_r[gi] <= PIN_RST[gi];
                    sync3_r[gi] <= PIN_RST[gi];
                    flt_r[gi] <= PIN_RST[gi];
                end else begin
                    sync1_r[gi] <= pins_i[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        flt_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    assign pins_f = csp_pins_s'(flt_r);

    ////////////////////////////////////////////////////////////////////////////////
    // phase sequencing

    // edge detector on the filtered init level; it resets to the idle-high pin level
    // so that leaving reset never reads as a false rise
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            init_prev_r <= 1'b1;
        end else begin
            init_prev_r <= pins_f.init;
        end
    end

    assign init_rise = pins_f.init && !init_prev_r;

    // clear interval: init is held low by us for a fixed count after reset
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clr_cnt_r <= CLR_CNT_RST;
        end else if (state_r == CSP_ST_CLEAR && clr_cnt_r != CLR_LAST) begin
            clr_cnt_r <= clr_cnt_r + 1'b1;
        end
    end

    // next phase; a low init from outside keeps us waiting since only its rise moves on
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CSP_ST_CLEAR: begin
                if (clr_cnt_r == CLR_LAST) begin
                    state_nxt = CSP_ST_WAIT;
                end
            end
            CSP_ST_WAIT: begin
                if (init_rise) begin // RULE_09
                    state_nxt = CSP_ST_CONFIG;
                end
            end
            CSP_ST_CONFIG: begin
                if (load_done_i) begin
                    state_nxt = CSP_ST_DONE;
                end
            end
            CSP_ST_DONE: begin
                state_nxt = CSP_ST_DONE;
            end
            default: begin
                state_nxt = CSP_ST_CLEAR;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= CSP_ST_CLEAR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // mode pins latched once, on the init rise that starts configuration
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_r <= MODE_RST;
        end else if (state_r == CSP_ST_WAIT && init_rise) begin
            mode_r <= pins_f.mode; // RULE_12
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // select decode and status outputs

    // select pins only mean something in the modes that use them
    assign sel_mode = (mode_r == MODE_ASYNC_PERIPH) || (mode_r == MODE_SLAVE_PAR)
                      || (mode_r == MODE_MICRO);
    assign sel_now = sel_mode && !pins_f.select_low_input && pins_f.select_high_input; // RULE_10
    assign in_cfg_nxt = (state_r == CSP_ST_CONFIG) && (state_nxt == CSP_ST_CONFIG);

    // open-drain enables and progress flags registered from the next phase; the pin level od_r is a fixed OD_LEVEL
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            od_r <= OD_LEVEL;
            init_oe_o <= 1'b1;
            done_oe_o <= 1'b1;
            cfg_active_high_flag_o <= HIGH_FLAG_RST;
            cfg_active_low_flag_o <= LOW_FLAG_RST;
        end else begin
            od_r <= OD_LEVEL;
            init_oe_o <= (state_nxt == CSP_ST_CLEAR); // RULE_08
            done_oe_o <= (state_nxt != CSP_ST_DONE); // RULE_13
            cfg_active_high_flag_o <= (state_nxt != CSP_ST_DONE); // RULE_06
            cfg_active_low_flag_o <= (state_nxt == CSP_ST_DONE); // RULE_07
        end
    end

    assign init_o = od_r;
    assign done_o = od_r;

    // ready pin: byte-ready level in async peripheral mode, read strobe in master parallel
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdy_o <= 1'b0;
        end else if (in_cfg_nxt && mode_r == MODE_ASYNC_PERIPH) begin
            rdy_o <= !byte_busy_i; // RULE_03
        end else if (in_cfg_nxt && mode_r == MODE_MASTER_PAR) begin
            rdy_o <= fetch_req_i; // RULE_05
        end else begin
            rdy_o <= 1'b0;
        end
    end

    // status mirror on the data line; a write strobe overrides a read
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_data_line_o <= 1'b0;
            status_data_line_oe_o <= 1'b0;
            selected_o <= 1'b0;
        end else begin
            selected_o <= in_cfg_nxt && sel_now;
            status_data_line_o <= !byte_busy_i; // RULE_04
            status_data_line_oe_o <= in_cfg_nxt && sel_now && (mode_r == MODE_ASYNC_PERIPH)
                                     && !pins_f.rd_b && pins_f.wr_b; // RULE_04
        end
    end

    // scan gating: scan stays live during configuration so tck/tms hold its state machine
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bscan_en_o <= 1'b1;
            jtag_user_io_o <= 1'b0;
            scan_hold_err_o <= 1'b0;
            mode_o <= MODE_RST;
        end else begin
            bscan_en_o <= (state_nxt != CSP_ST_DONE) || bscan_sel_i; // RULE_01
            jtag_user_io_o <= (state_nxt == CSP_ST_DONE) && !bscan_sel_i; // RULE_11
            // sticky flag: both scan lines low during configuration may upset the tap
            scan_hold_err_o <= scan_hold_err_o
                               || (state_r == CSP_ST_CONFIG && !pins_f.tck && !pins_f.tms); // RULE_02
            mode_o <= (state_r == CSP_ST_WAIT && init_rise) ? pins_f.mode : mode_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions and covers

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    AST_SCAN_OFF: assert property ((state_nxt == CSP_ST_DONE && !bscan_sel_i) |=> !bscan_en_o) // RULE_01
        else $error("scan still enabled after configuration");
    AST_RDY_ASYNC: assert property ((in_cfg_nxt && mode_r == MODE_ASYNC_PERIPH) // RULE_03
        |=> rdy_o == !$past(byte_busy_i))
        else $error("ready does not follow byte busy");
    AST_D7_MIRROR: assert property (status_data_line_oe_o |-> status_data_line_o == rdy_o // RULE_04
        && selected_o)
        else $error("status data line differs from ready");
    AST_RCLK: assert property ((in_cfg_nxt && mode_r == MODE_MASTER_PAR) // RULE_05
        |=> rdy_o == $past(fetch_req_i))
        else $error("read strobe does not follow fetch request");
    AST_HIGH_FLAG: assert property ($past(state_nxt) != CSP_ST_DONE |-> cfg_active_high_flag_o) // RULE_06
        else $error("active-high flag dropped early");
    AST_LOW_FLAG: assert property (cfg_active_low_flag_o == !cfg_active_high_flag_o) // RULE_07
        else $error("progress flags disagree");
    AST_INIT_LOW: assert property ((state_r == CSP_ST_CLEAR && state_nxt == CSP_ST_CLEAR) // RULE_08
        |=> init_oe_o && !init_o)
        else $error("init released during clear");
    AST_WAIT_HOLD: assert property ((state_r == CSP_ST_WAIT && !pins_f.init) // RULE_09
        |=> state_r == CSP_ST_WAIT)
        else $error("left wait while init low");
    AST_SELECT: assert property (selected_o |-> $past(!pins_f.select_low_input // RULE_10
        && pins_f.select_high_input && sel_mode))
        else $error("selected without proper select levels");
    AST_USER_IO: assert property ((state_r == CSP_ST_DONE && !bscan_sel_i) |=> jtag_user_io_o) // RULE_11
        else $error("scan pins not handed to user");
    AST_MODE_LATCH: assert property ((state_r == CSP_ST_WAIT && init_rise) // RULE_12
        |=> mode_r == $past(pins_f.mode) && state_r == CSP_ST_CONFIG)
        else $error("mode not captured at init rise");
    AST_DONE_REL: assert property ((state_r == CSP_ST_CONFIG && load_done_i) // RULE_13
        |=> !done_oe_o ##1 !done_oe_o)
        else $error("done not released");

    COV_DONE: cover property (state_r == CSP_ST_CONFIG ##1 state_r == CSP_ST_DONE);
    COV_D7_READ: cover property (status_data_line_oe_o);
    COV_STROBE: cover property (mode_r == MODE_MASTER_PAR && rdy_o);
    COV_WAIT_LONG: cover property (state_r == CSP_ST_WAIT && !pins_f.init [*4]);

endmodule

// file: csp_host_model.sv
// configuration host model driving the pin bundle of the status and select block
module csp_host_model (
    input wire logic init_oe_i,
    input wire logic hold_low_i,
    input wire logic [csp_pkg::MODE_W-1:0] mode_i,
    input wire logic sel_low_i,
    input wire logic sel_high_i,
    input wire logic rd_i,
    output csp_pkg::csp_pins_s pins_o
);
    import csp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // init is open drain with a pull-up, so either side pulling wins; the selects
    // go out raw because decoding them is the device's job; the write strobe
    // stays idle so a read is never overridden; tck and tms are parked high for
    // the whole run so the scan port never sees a stuck-low pair
    assign pins_o = '{
        init: ~(init_oe_i | hold_low_i),
        select_low_input: sel_low_i,
        select_high_input: sel_high_i,
        rd_b: ~rd_i,
        wr_b: 1'b1,
        tck: 1'b1,
        tms: 1'b1,
        mode: mode_i
    };
endmodule

// file: csp_pkg.sv
// constants, state codes and pin bundle of the configuration status and select pin block
package csp_pkg;

    // system clock period and the memory-clear interval after power-up
    localparam int CLK_PERIOD_NS = 40;
    localparam int CLEAR_TIME_NS = 2000;
    localparam int CLEAR_CYCLES = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLR_CNT_W = 8;
    localparam logic [CLR_CNT_W-1:0] CLR_LAST = CLR_CNT_W'(CLEAR_CYCLES - 1);
    localparam logic [CLR_CNT_W-1:0] CLR_CNT_RST = 8'h00;

    // configuration mode codes as seen on the mode selection pins
    localparam int MODE_W = 4;
    localparam logic [MODE_W-1:0] MODE_MASTER_PAR = 4'h4;
    localparam logic [MODE_W-1:0] MODE_ASYNC_PERIPH = 4'h5;
    localparam logic [MODE_W-1:0] MODE_SLAVE_PAR = 4'h7;
    localparam logic [MODE_W-1:0] MODE_MICRO = 4'h3;
    localparam logic [MODE_W-1:0] MODE_RST = 4'h0;

    // reset values of the pin-facing flops
    localparam logic HIGH_FLAG_RST = 1'b1;
    localparam logic LOW_FLAG_RST = 1'b0;
    localparam logic OD_LEVEL = 1'b0;

    // configuration phases
    typedef enum logic [3:0] {
        CSP_ST_CLEAR = 4'b0001,
        CSP_ST_WAIT = 4'b0010,
        CSP_ST_CONFIG = 4'b0100,
        CSP_ST_DONE = 4'b1000
    } csp_state_e;

    // pins arriving from outside the clock domain
    typedef struct packed {
        logic init;
        logic select_low_input;
        logic select_high_input;
        logic rd_b;
        logic wr_b;
        logic tck;
        logic tms;
        logic [MODE_W-1:0] mode;
    } csp_pins_s;

    localparam int PIN_W = $bits(csp_pins_s);
    localparam logic [PIN_W-1:0] PIN_RST = 11'h7ff;

endpackage

// file: testbench.sv
// self-checking bench for the configuration control block with a host model
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import csp_pkg::*;

    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic load_done = 1'b0;
    logic byte_busy = 1'b0;
    logic fetch_req = 1'b0;
    logic bscan_sel = 1'b0;
    logic hold_low = 1'b1;
    logic sel_low = 1'b1;
    logic sel_high = 1'b0;
    logic rd = 1'b0;
    logic [MODE_W-1:0] mode_pin = MODE_RST;
    csp_pins_s pins;
    logic init_v, init_oe, done_v, done_oe, flag_hi, flag_lo, rdy, d7, d7_oe, sel_o;
    logic bscan_en, user_io, hold_err, exp_busy, exp_fetch;
    logic [MODE_W-1:0] mode_o;
    logic [MODE_W-1:0] modes [4] = '{MODE_MASTER_PAR, MODE_ASYNC_PERIPH, MODE_SLAVE_PAR, MODE_MICRO};
    int seed = 39474;
    int n_fail = 0;
    int checks_done = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // clock, host model and design
    always #20 clk_sys_i = ~clk_sys_i;

    csp_host_model host (.init_oe_i(init_oe), .hold_low_i(hold_low), .mode_i(mode_pin),
        .sel_low_i(sel_low), .sel_high_i(sel_high), .rd_i(rd), .pins_o(pins));

    csp_cfg_ctrl uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .pins_i(pins),
        .load_done_i(load_done), .byte_busy_i(byte_busy), .fetch_req_i(fetch_req),
        .bscan_sel_i(bscan_sel), .init_o(init_v), .init_oe_o(init_oe), .done_o(done_v),
        .done_oe_o(done_oe), .cfg_active_high_flag_o(flag_hi), .cfg_active_low_flag_o(flag_lo),
        .rdy_o(rdy), .status_data_line_o(d7), .status_data_line_oe_o(d7_oe),
        .selected_o(sel_o), .mode_o(mode_o), .bscan_en_o(bscan_en),
        .jtag_user_io_o(user_io), .scan_hold_err_o(hold_err));

    ////////////////////////////////////////////////////////////////////////////////
    // expectations from the mode and the pins
    function automatic logic exp_rdy(input logic [MODE_W-1:0] m, input logic b, input logic f);
        return (m == MODE_ASYNC_PERIPH) ? ~b : ((m == MODE_MASTER_PAR) ? f : 1'b0);
    endfunction

    // every mode but master parallel uses the two-line select
    function automatic logic exp_sel(input logic [MODE_W-1:0] m, input logic lo, input logic hi);
        return (m != MODE_MASTER_PAR) && !lo && hi;
    endfunction

    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // drives follow this at the edge; checks add #1 so the edge's updates land first
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // one full pass: reset, clear, held wait, config traffic, select table, done
    task automatic run_cfg(input logic [MODE_W-1:0] m);
        logic [2:0] c;
        int k;
        step(1);
        rst_b_i <= 1'b0;
        hold_low <= 1'b1;
        mode_pin <= m;
        bscan_sel <= 1'($random(seed));
        byte_busy <= 1'b0;
        fetch_req <= 1'b0;
        step(5);
        rst_b_i <= 1'b1;
        step(40);
        #1 chk("init_oe clear", init_oe, 1'b1);
        chk("init_o clear", init_v, 1'b0);
        chk("done_o clear", done_v, 1'b0);
        step(40);
        #1 chk("init_oe wait", init_oe, 1'b0);
        chk("mode held", mode_o, MODE_RST);
        chk("done_oe held", done_oe, 1'b1);
        step(1);
        hold_low <= 1'b0;
        k = 0;
        while (mode_o !== m && k < 20) begin
            step(1);
            #1 k++;
        end
        chk("mode", mode_o, m);
        // random traffic; the mode pins move but the captured mode must not
        for (k = 0; k < 40; k++) begin
            step(1);
            exp_busy = byte_busy;
            exp_fetch = fetch_req;
            byte_busy <= 1'($random(seed));
            fetch_req <= 1'($random(seed));
            if (k == 3) mode_pin <= ~m;
            #1 chk("rdy", rdy, exp_rdy(m, exp_busy, exp_fetch));
            chk("d7", d7, !exp_busy);
            chk("flag_hi", flag_hi, 1'b1);
            chk("flag_lo", flag_lo, 1'b0);
        end
        chk("mode kept", mode_o, m);
        chk("bscan_en cfg", bscan_en, 1'b1);
        chk("user_io cfg", user_io, 1'b0);
        chk("hold_err", hold_err, 1'b0);
        chk("done_oe cfg", done_oe, 1'b1);
        // every select and read combination, held past the pin filter
        for (k = 0; k < 8; k++) begin
            step(1);
            c = 3'(k);
            sel_low <= c[2];
            sel_high <= c[1];
            rd <= c[0];
            step(8);
            #1 chk("selected", sel_o, exp_sel(m, c[2], c[1]));
            chk("d7_oe", d7_oe, (m == MODE_ASYNC_PERIPH) && !c[2] && c[1] && c[0]);
        end
        step(1);
        load_done <= 1'b1;
        step(1);
        load_done <= 1'b0;
        #1 chk("done_oe", done_oe, 1'b0);
        chk("flag_hi done", flag_hi, 1'b0);
        chk("flag_lo done", flag_lo, 1'b1);
        chk("bscan_en done", bscan_en, bscan_sel);
        chk("user_io done", user_io, !bscan_sel);
        chk("rdy done", rdy, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // each mode once, then random picks; each pass after the first resets again in mid-run
    initial begin
        for (int i = 0; i < 6; i++) begin
            run_cfg(i < 4 ? modes[i] : modes[$random(seed) & 3]);
        end
        wrap_up();
    end

    // a hang costs a mismatch; the passes need well under 2000 cycles
    initial begin
        #(CLK_PERIOD_NS * 5000);
        n_fail++;
        wrap_up();
    end
endmodule
